// File: rtl/eaf_pkg.sv
// Purpose: constants for the external address filter port
// Assumes: 32-bit register port, 16-bit registers in the low bits
// Notes: offsets are byte addresses
`default_nettype none

package eaf_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BUSCFG = 8'h04;
    localparam logic [7:0] OFS_MODE = 8'h08;
    localparam logic [7:0] OFS_HASH_LO = 8'h0c;
    localparam logic [7:0] OFS_HASH_HI = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // control_status_reg_zero fields
    localparam int unsigned CTRL_RUN_BIT = 1;
    // bus_config_reg_2 fields
    localparam int unsigned BUSCFG_EXT_SEL_BIT = 3;
    localparam int unsigned BUSCFG_TEST_SRC_BIT = 4;
    // mode_register fields
    localparam int unsigned MODE_RX_OFF_BIT = 0;
    localparam int unsigned MODE_TX_OFF_BIT = 1;
    localparam int unsigned MODE_REJ_UNI_BIT = 11;
    localparam int unsigned MODE_ACC_ALL_BIT = 15;
    // status fields
    localparam int unsigned STAT_WINDOW_BIT = 0;
    localparam int unsigned STAT_REJ_SEEN_BIT = 1;
    localparam int unsigned STAT_LAST_ACC_BIT = 2;
    localparam int unsigned STAT_LAST_DISC_BIT = 3;
    localparam int unsigned STAT_EXT_ON_BIT = 4;

    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] BUSCFG_RST = 16'h0000;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [31:0] HASH_RST = 32'h0000_0000;

    // decision window in bit times after the delimiter
    localparam int unsigned WINDOW_BYTES = 64;
    localparam logic [9:0] WINDOW_BITS = 10'(WINDOW_BYTES * 8);
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

    // least reject pulse width and its count at the system clock
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned REJ_MIN_NS = 200;
    localparam int unsigned REJ_MIN_CYC = (REJ_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        LNK_IDLE = 3'b001,
        LNK_PREAMBLE = 3'b010,
        LNK_BYTES = 3'b100
    } eaf_link_state_t;

endpackage

`default_nettype wire

// File: rtl/eaf_port.sv
// Purpose: external address detection tap on the receive path
// Assumes: rx_clk is the recovered receive clock, source data are on that clock
// Notes: register port answers reads one cycle later; unmapped reads give zero
//
// Operation
// - external outputs and reject input work only when ext_filter_select is set
// - tap fed from decoder data and clock or serial test input
// - serial_receive_clock toggles only during frame reception
// - frame_byte_marker rises on the two ones ending the delimiter
// - frame_byte_marker strobes each byte boundary after the delimiter
// - internal address match accepts the frame whatever the reject input
// - unmatched frames keep being received until the window closes
// - reject ignored after 512 bit times; no reject means accept
// - accept_all_frames receives everything and ignores the reject input
// - reject_unicast_physical with empty hash leaves only the external decision
// - interface keeps running under controller_run with receiver and transmitter off
// - no bus DMA while receiver and transmitter are both off
//
// The register offsets and strobed register access were decided locally.
`default_nettype none

module eaf_port (
    input wire logic clock,
    input wire logic reset_n,
    // register port
    input wire logic [eaf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [eaf_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [eaf_pkg::DATA_W-1:0] reg_rdata,
    // receive path sources, on rx_clk
    input wire logic rx_clk,
    input wire logic dec_data,
    input wire logic dec_active,
    input wire logic test_data,
    input wire logic test_active,
    // internal address comparison result, stable at frame end
    input wire logic station_phys_match,
    input wire logic station_logical_match,
    // external pins
    output logic serial_receive_clock,
    output logic serial_receive_bitstream,
    output logic frame_byte_marker,
    input wire logic external_reject_n,
    // frame decision and dma gating
    output logic frame_accept,
    output logic frame_discard,
    output logic rx_dma_enable,
    output logic tx_dma_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0] ctrl_r;
    logic [15:0] buscfg_r;
    logic [15:0] mode_r;
    logic [31:0] hash_lo_r;
    logic [31:0] hash_hi_r;
    logic [eaf_pkg::DATA_W-1:0] rdata_r;

    wire sel_ctrl = reg_addr == eaf_pkg::OFS_CTRL;
    wire sel_buscfg = reg_addr == eaf_pkg::OFS_BUSCFG;
    wire sel_mode = reg_addr == eaf_pkg::OFS_MODE;
    wire sel_hash_lo = reg_addr == eaf_pkg::OFS_HASH_LO;
    wire sel_hash_hi = reg_addr == eaf_pkg::OFS_HASH_HI;
    wire sel_status = reg_addr == eaf_pkg::OFS_STATUS;

    wire run = ctrl_r[eaf_pkg::CTRL_RUN_BIT];
    wire ext_select = buscfg_r[eaf_pkg::BUSCFG_EXT_SEL_BIT];
    wire test_src = buscfg_r[eaf_pkg::BUSCFG_TEST_SRC_BIT];
    wire rx_off = mode_r[eaf_pkg::MODE_RX_OFF_BIT];
    wire tx_off = mode_r[eaf_pkg::MODE_TX_OFF_BIT];
    wire rej_unicast = mode_r[eaf_pkg::MODE_REJ_UNI_BIT];
    wire accept_all = mode_r[eaf_pkg::MODE_ACC_ALL_BIT];
    wire hash_nonzero = |{hash_hi_r, hash_lo_r};

    wire ext_on = ext_select & run;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= eaf_pkg::CTRL_RST;
            buscfg_r <= eaf_pkg::BUSCFG_RST;
            mode_r <= eaf_pkg::MODE_RST;
            hash_lo_r <= eaf_pkg::HASH_RST;
            hash_hi_r <= eaf_pkg::HASH_RST;
        end else if (reg_write) begin
            if (sel_ctrl) ctrl_r <= reg_wdata[15:0];
            if (sel_buscfg) buscfg_r <= reg_wdata[15:0];
            if (sel_mode) mode_r <= reg_wdata[15:0];
            if (sel_hash_lo) hash_lo_r <= reg_wdata;
            if (sel_hash_hi) hash_hi_r <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // config into the link domain
    logic [1:0] lk_en_meta_r;
    logic [1:0] lk_en_r;

    always_ff @(posedge rx_clk or negedge reset_n) begin
        if (!reset_n) begin
            lk_en_meta_r <= 2'h0;
            lk_en_r <= 2'h0;
        end else begin
            lk_en_meta_r <= {test_src, ext_on};
            lk_en_r <= lk_en_meta_r;
        end
    end

    wire lk_ext_on = lk_en_r[0];

    wire src_data = lk_en_r[1] ? test_data : dec_data;
    wire src_active = lk_en_r[1] ? test_active : dec_active;

    ////////////////////////////////////////////////////////////////////////////
    // link domain: delimiter hunt and byte strobe
    eaf_pkg::eaf_link_state_t st_r;
    eaf_pkg::eaf_link_state_t st_nxt;
    logic prev_bit_r;
    logic [9:0] bit_cnt_r;
    logic window_r;
    logic marker_r;
    logic data_r;
    logic gate_r;
    logic end_tgl_r;

    wire frame_on = lk_ext_on & src_active;
    wire sfd_seen = prev_bit_r & src_data;
    wire byte_edge = bit_cnt_r[2:0] == eaf_pkg::BYTE_LAST_BIT;
    wire window_done = bit_cnt_r == eaf_pkg::WINDOW_BITS - 10'h1;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            eaf_pkg::LNK_IDLE: if (frame_on) st_nxt = eaf_pkg::LNK_PREAMBLE;
            eaf_pkg::LNK_PREAMBLE: begin
                if (!frame_on) st_nxt = eaf_pkg::LNK_IDLE;
                else if (sfd_seen) st_nxt = eaf_pkg::LNK_BYTES;
            end
            eaf_pkg::LNK_BYTES: if (!frame_on) st_nxt = eaf_pkg::LNK_IDLE;
            default: st_nxt = eaf_pkg::LNK_IDLE;
        endcase
    end

    wire in_pre = st_r == eaf_pkg::LNK_PREAMBLE;
    wire in_bytes = st_r == eaf_pkg::LNK_BYTES;
    wire frame_ends = (in_pre | in_bytes) & !frame_on;

    always_ff @(posedge rx_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= eaf_pkg::LNK_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge rx_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_bit_r <= 1'b0;
            data_r <= 1'b0;
        end else begin
            prev_bit_r <= frame_on & in_pre & src_data;
            data_r <= frame_on & src_data;
        end
    end

    always_ff @(posedge rx_clk or negedge reset_n) begin
        if (!reset_n) begin
            marker_r <= 1'b0;
        end else begin
            marker_r <= frame_on & ((in_pre & sfd_seen) | (in_bytes & byte_edge));
        end
    end

    // window counts 512 bits from the delimiter
    // frame runs on while window open
    always_ff @(posedge rx_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_r <= 10'h0;
            window_r <= 1'b0;
        end else if (in_pre & frame_on & sfd_seen) begin
            bit_cnt_r <= 10'h0;
            window_r <= 1'b1;
        end else if (in_bytes & frame_on) begin
            bit_cnt_r <= bit_cnt_r + 10'h1;
            if (window_done) window_r <= 1'b0;
        end else begin
            window_r <= 1'b0;
        end
    end

    always_ff @(posedge rx_clk or negedge reset_n) begin
        if (!reset_n) begin
            end_tgl_r <= 1'b0;
        end else if (frame_ends) begin
            end_tgl_r <= ~end_tgl_r;
        end
    end

    // clock gate, changed while rx_clk is low
    always_ff @(negedge rx_clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_r <= 1'b0;
        end else begin
            gate_r <= frame_on;
        end
    end

    assign serial_receive_clock = rx_clk & gate_r;
    assign serial_receive_bitstream = data_r;
    assign frame_byte_marker = marker_r;

    ////////////////////////////////////////////////////////////////////////////
    // system domain: crossings
    logic win_meta_r;
    logic win_sync_r;
    logic win_d_r;
    logic [2:0] end_sync_r;
    logic rej_meta_r;
    logic rej_sync_r;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            win_meta_r <= 1'b0;
            win_sync_r <= 1'b0;
            win_d_r <= 1'b0;
            end_sync_r <= 3'h0;
            rej_meta_r <= 1'b1;
            rej_sync_r <= 1'b1;
        end else begin
            win_meta_r <= window_r;
            win_sync_r <= win_meta_r;
            win_d_r <= win_sync_r;
            end_sync_r <= {end_sync_r[1:0], end_tgl_r};
            rej_meta_r <= external_reject_n;
            rej_sync_r <= rej_meta_r;
        end
    end

    wire win_start = win_sync_r & !win_d_r;
    wire frame_done = end_sync_r[2] ^ end_sync_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // system domain: accept or discard decision
    logic rej_seen_r;
    logic accept_r;
    logic discard_r;
    logic last_acc_r;
    logic last_disc_r;

    // reject only counts inside the window
    wire rej_hit = win_sync_r & !rej_sync_r & ext_on;

    // physical match off and empty hash leave only the external decision
    wire int_match = (station_phys_match & !rej_unicast) | (station_logical_match & hash_nonzero);

    wire keep_frame = accept_all | int_match | !rej_seen_r;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rej_seen_r <= 1'b0;
        end else if (rej_hit) begin
            rej_seen_r <= 1'b1;
        end else if (win_start) begin
            rej_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            accept_r <= 1'b0;
            discard_r <= 1'b0;
        end else begin
            accept_r <= frame_done & keep_frame;
            discard_r <= frame_done & !keep_frame;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            last_acc_r <= 1'b0;
            last_disc_r <= 1'b0;
        end else if (frame_done) begin
            last_acc_r <= keep_frame;
            last_disc_r <= !keep_frame;
        end
    end

    assign frame_accept = accept_r;
    assign frame_discard = discard_r;

    ////////////////////////////////////////////////////////////////////////////
    // dma gating
    logic rx_dma_r;
    logic tx_dma_r;

    // no dma with receiver and transmitter off
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_dma_r <= 1'b0;
            tx_dma_r <= 1'b0;
        end else begin
            rx_dma_r <= run & !rx_off;
            tx_dma_r <= run & !tx_off;
        end
    end

    assign rx_dma_enable = rx_dma_r;
    assign tx_dma_enable = tx_dma_r;

    ////////////////////////////////////////////////////////////////////////////
    // read data
    logic [15:0] status_w;

    always_comb begin
        status_w = 16'h0000;
        status_w[eaf_pkg::STAT_WINDOW_BIT] = win_sync_r;
        status_w[eaf_pkg::STAT_REJ_SEEN_BIT] = rej_seen_r;
        status_w[eaf_pkg::STAT_LAST_ACC_BIT] = last_acc_r;
        status_w[eaf_pkg::STAT_LAST_DISC_BIT] = last_disc_r;
        status_w[eaf_pkg::STAT_EXT_ON_BIT] = ext_on;
    end

    wire [31:0] rd_mux = sel_ctrl ? {16'h0000, ctrl_r} :
                         sel_buscfg ? {16'h0000, buscfg_r} :
                         sel_mode ? {16'h0000, mode_r} :
                         sel_hash_lo ? hash_lo_r :
                         sel_hash_hi ? hash_hi_r :
                         sel_status ? {16'h0000, status_w} : 32'h0000_0000;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= reg_read ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_r;

endmodule

`default_nettype wire

// File: sim/eaf_far_end.sv
// Purpose: far-end address comparison model
// Assumes: bytes arrive first bit first after each marker
// Notes: rejects when the first byte equals bad_addr
`default_nettype none

module eaf_far_end (
    input wire logic clock,
    input wire logic serial_receive_clock,
    input wire logic serial_receive_bitstream,
    input wire logic frame_byte_marker,
    input wire logic arm,
    input wire logic [7:0] bad_addr,
    input wire logic [7:0] rej_byte,
    output logic external_reject_n,
    output logic [7:0] first_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sr;
    logic [7:0] nbytes;
    logic fired;
    int hold = 0;
    wire logic [7:0] word = {serial_receive_bitstream, sr[7:1]};

    always @(posedge serial_receive_clock or posedge arm) begin
        if (arm) begin
            nbytes <= 8'hff;
        end else begin
            sr <= word;
            if (frame_byte_marker)
                nbytes <= nbytes + 8'h01;
            if (frame_byte_marker && nbytes == 8'h00)
                first_byte <= word;
        end
    end
    ////////////////////////////////////////
    // reject low 200 ns
    assign external_reject_n = hold == 0;
    always @(posedge clock) begin
        if (hold > 0)
            hold <= hold - 1;
        if (arm)
            fired <= 1'b0;
        else if (!fired && nbytes == rej_byte && first_byte == bad_addr) begin
            fired <= 1'b1;
            hold <= 50;
        end
    end
endmodule
`default_nettype wire

// File: sim/eaf_port_assertions.sv
// Purpose: port checks for eaf_port
// Assumes: decisions and markers are one-cycle pulses
// Notes: bound into every eaf_port
`default_nettype none

module eaf_port_assertions (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic rx_clk,
    input wire logic frame_byte_marker,
    input wire logic frame_accept,
    input wire logic frame_discard,
    input wire logic rx_dma_enable,
    input wire logic tx_dma_enable
);
    timeunit 1ns;
    timeprecision 100ps;
    logic acc_all_r;
    logic ext_r;
    wire logic mode_wr = reg_write && reg_addr == eaf_pkg::OFS_MODE;

    // mirrors the software settings that gate decisions
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            acc_all_r <= 1'b0;
            ext_r <= 1'b0;
        end else if (mode_wr) begin
            acc_all_r <= reg_wdata[eaf_pkg::MODE_ACC_ALL_BIT];
        end else if (reg_write && reg_addr == eaf_pkg::OFS_BUSCFG) begin
            ext_r <= reg_wdata[eaf_pkg::BUSCFG_EXT_SEL_BIT];
        end
    end
    ////////////////////////////////////////
    one_decision_a: assert property (@(posedge clock) disable iff (!reset_n)
        !(frame_accept && frame_discard)) else $error("accept and discard together");
    decision_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
        frame_accept || frame_discard |=> !frame_accept && !frame_discard) else $error("decision too long");
    promisc_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
        acc_all_r |-> !frame_discard) else $error("discard under accept all");
    byte_gap_a: assert property (@(posedge rx_clk) disable iff (!reset_n)
        frame_byte_marker |=> !frame_byte_marker [*7]) else $error("marker spacing");
    rx_dma_off_a: assert property (@(posedge clock) disable iff (!reset_n)
        mode_wr && reg_wdata[0] |=> ##1 !rx_dma_enable) else $error("rx dma on");
    tx_dma_off_a: assert property (@(posedge clock) disable iff (!reset_n)
        mode_wr && reg_wdata[1] |=> ##1 !tx_dma_enable) else $error("tx dma on");
    ext_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
        !ext_r |-> !frame_byte_marker) else $error("marker while off");
    read_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
        !reg_read |=> reg_rdata == 32'h0) else $error("read data not idle");
endmodule

bind eaf_port eaf_port_assertions eaf_port_assertions_i (.clock(clock), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .rx_clk(rx_clk), .frame_byte_marker(frame_byte_marker),
    .frame_accept(frame_accept), .frame_discard(frame_discard), .rx_dma_enable(rx_dma_enable),
    .tx_dma_enable(tx_dma_enable));
`default_nettype wire

// File: sim/tb.sv
// Purpose: self-checking bench for eaf_port
// Assumes: far end rejects frames whose first byte is a5
// Notes: rx_clk runs only around frames and during reset
`default_nettype none
`define CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("FAIL %0t got %0h exp %0h", $time, g, e); \
    end \
end

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, reset_n, reg_write, reg_read, rx_clk, rx_run, lead, arm, use_test;
    logic dec_data, dec_active, test_data, test_active, station_phys_match, station_logical_match;
    logic serial_receive_clock, serial_receive_bitstream, frame_byte_marker, external_reject_n;
    logic frame_accept, frame_discard, rx_dma_enable, tx_dma_enable;
    logic [7:0] reg_addr, rej_byte, first_byte;
    logic [31:0] reg_wdata, reg_rdata, rdv;
    int miscompares, compares, acc_n, disc_n, mk_n, lead_n;

    eaf_port eaf_port_i (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .rx_clk(rx_clk),
        .dec_data(dec_data), .dec_active(dec_active), .test_data(test_data), .test_active(test_active),
        .station_phys_match(station_phys_match), .station_logical_match(station_logical_match),
        .serial_receive_clock(serial_receive_clock), .serial_receive_bitstream(serial_receive_bitstream),
        .frame_byte_marker(frame_byte_marker), .external_reject_n(external_reject_n),
        .frame_accept(frame_accept), .frame_discard(frame_discard), .rx_dma_enable(rx_dma_enable),
        .tx_dma_enable(tx_dma_enable));
    eaf_far_end eaf_far_end_i (.clock(clock), .serial_receive_clock(serial_receive_clock),
        .serial_receive_bitstream(serial_receive_bitstream), .frame_byte_marker(frame_byte_marker),
        .arm(arm), .bad_addr(8'ha5), .rej_byte(rej_byte), .external_reject_n(external_reject_n),
        .first_byte(first_byte));
    ////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        rx_clk = 1'b0;
        #0.7;
        forever #3 rx_clk = rx_run ? ~rx_clk : rx_clk;
    end
    always @(posedge clock) begin
        acc_n += (frame_accept === 1'b1);
        disc_n += (frame_discard === 1'b1);
    end
    always @(posedge rx_clk) mk_n += (frame_byte_marker === 1'b1);
    always @(posedge serial_receive_clock) lead_n += lead;

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 rdv = reg_rdata;
    endtask
    task automatic drive(input logic a, d);
        dec_active <= a & ~use_test;
        test_active <= a & use_test;
        // the unused source carries zeros so a wrong source select shows up in the marker and decision counts
        dec_data <= d & ~use_test;
        test_data <= d & use_test;
    endtask
    // frame: delimiter pattern, address byte, filler, first bit first
    task automatic send(input logic [7:0] da, input int nb);
        logic [7:0] b;
        rx_run = 1'b1;
        lead = 1'b1;
        repeat (4) @(posedge rx_clk);
        lead = 1'b0;
        for (int i = 0; i < 8 * nb + 8; i++) begin
            b = i < 8 ? 8'hd5 : (i < 16 ? da : 8'h55);
            drive(1'b1, b[i % 8]);
            @(posedge rx_clk);
        end
        drive(1'b0, ~b[7]);
        // trailing edges must stay gated as well
        lead <= 1'b1;
        repeat (4) @(posedge rx_clk);
        rx_run = 1'b0;
    endtask
    task automatic run_case(input logic [15:0] mode, cfg, input logic pm, lm, input logic [7:0] da, rb,
        input int nb, ea, ed);
        wr(eaf_pkg::OFS_MODE, {16'h0, mode});
        wr(eaf_pkg::OFS_BUSCFG, {16'h0, cfg});
        station_phys_match <= pm;
        station_logical_match <= lm;
        rej_byte <= rb;
        use_test = cfg[eaf_pkg::BUSCFG_TEST_SRC_BIT];
        arm <= 1'b1;
        @(posedge clock);
        arm <= 1'b0;
        acc_n = 0;
        disc_n = 0;
        mk_n = 0;
        lead_n = 0;
        send(da, nb);
        repeat (20) @(posedge clock);
        `CHK(acc_n, ea)
        `CHK(disc_n, ed)
        `CHK(lead_n, 0)
        `CHK(frame_byte_marker, 1'b0)
        `CHK(mk_n, cfg[3] ? nb + 1 : 0)
        `CHK({frame_accept, frame_discard}, 2'b00)
        if (cfg[3])
            `CHK(first_byte, da)
    endtask
    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        close_out();
    end
    initial begin
        {reg_write, reg_read, arm, lead, use_test, station_phys_match, station_logical_match} = '0;
        {reg_addr, reg_wdata, rej_byte} = '0;
        drive(1'b0, 1'b0);
        reset_n = 1'b0;
        rx_run = 1'b1;
        repeat (2) @(posedge rx_clk);
        @(posedge clock);
        reset_n <= 1'b1;
        rx_run = 1'b0;
        for (int i = 0; i <= 'h14; i += 4) begin
            rd(8'(i));
            `CHK(rdv, 32'h0)
        end
        wr(8'h18, 32'hffff_ffff);
        rd(8'h18);
        `CHK(rdv, 32'h0)
        wr(eaf_pkg::OFS_MODE, 32'hffff_0800);
        rd(eaf_pkg::OFS_MODE);
        `CHK(rdv, 32'h0000_0800)
        wr(eaf_pkg::OFS_CTRL, 32'h2);
        // the enables follow the control write by one registered stage
        repeat (2) @(posedge clock);
        `CHK({rx_dma_enable, tx_dma_enable}, 2'b11)
        run_case(16'h0800, 16'h0008, 1'b1, 1'b1, 8'ha5, 8'd6, 20, 0, 1);
        rd(eaf_pkg::OFS_STATUS);
        `CHK(rdv[4:0], 5'b11010)
        run_case(16'h0800, 16'h0008, 1'b0, 1'b0, 8'h3c, 8'd6, 20, 1, 0);
        run_case(16'h0800, 16'h0008, 1'b0, 1'b0, 8'ha5, 8'd66, 70, 1, 0);
        run_case(16'h0000, 16'h0008, 1'b1, 1'b0, 8'ha5, 8'd6, 20, 1, 0);
        wr(eaf_pkg::OFS_HASH_HI, 32'h8000_0000);
        run_case(16'h0800, 16'h0008, 1'b0, 1'b1, 8'ha5, 8'd6, 20, 1, 0);
        wr(eaf_pkg::OFS_HASH_HI, 32'h0);
        wr(eaf_pkg::OFS_HASH_LO, 32'h0000_0001);
        rd(eaf_pkg::OFS_HASH_LO);
        `CHK(rdv, 32'h0000_0001)
        run_case(16'h0800, 16'h0008, 1'b0, 1'b1, 8'ha5, 8'd6, 20, 1, 0);
        wr(eaf_pkg::OFS_HASH_LO, 32'h0);
        run_case(16'h8800, 16'h0008, 1'b0, 1'b0, 8'ha5, 8'd6, 20, 1, 0);
        run_case(16'h0800, 16'h0018, 1'b0, 1'b0, 8'ha5, 8'd6, 20, 0, 1);
        run_case(16'h0803, 16'h0008, 1'b0, 1'b0, 8'ha5, 8'd6, 20, 0, 1);
        `CHK({rx_dma_enable, tx_dma_enable}, 2'b00)
        run_case(16'h0800, 16'h0000, 1'b0, 1'b0, 8'ha5, 8'd6, 20, 0, 0);
        close_out();
    end
endmodule
`default_nettype wire
